// file: rtl/lbhs_top.sv
// local bus hold handshake, chip selects and transceiver controls
`timescale 1ns/1ps
`default_nettype none
module lbhs_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_request_pin,
  input wire logic upper_region_select_in,
  input wire logic lower_region_select_in,
  input wire lbhs_pkg::lbhs_cycle_t cycle,
  input wire lbhs_pkg::lbhs_cfg_t cfg,
  input wire logic refresh_pending,
  output logic cycle_ack,
  output logic bus_grant_out,
  output logic bus_grant_oe,
  output logic bus_lines_oe,
  output logic lower_region_select,
  output logic lower_pullup_en,
  output logic [lbhs_pkg::MID_COUNT-1:0] midrange_selects,
  output logic [lbhs_pkg::PER_LOW_COUNT-1:0] peripheral_selects,
  output logic periph_sel5_or_latched_addr1,
  output logic periph_sel6_or_latched_addr2,
  output logic select_oe,
  output logic transceiver_direction,
  output logic transceiver_direction_oe,
  output logic transceiver_enable,
  output logic transceiver_enable_oe,
  output logic isolation_mode
);
  import lbhs_pkg::*;

  // block index of addr above base, or NO_BLOCK when below it
  function automatic logic [ADDR_W-1:0] blk_index(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] base,
    input logic [LOG2_W-1:0] lg
  );
    logic [ADDR_W-1:0] off;
    off = addr - base;
    if (addr < base)
    begin
      blk_index = NO_BLOCK;
    end
    else
    begin
      blk_index = off >> lg;
    end
  endfunction : blk_index

  lbhs_state_t state;
  logic req_meta;
  logic req_sync;
  logic ucs_meta;
  logic ucs_sync;
  logic lcs_meta;
  logic lcs_sync;
  logic srst_q;
  logic next_iso;
  logic grant_ok;
  logic lower_hit;
  logic [MID_COUNT-1:0] mid_hits;
  logic [PER_COUNT-1:0] per_hits;
  logic [ADDR_W-1:0] mid_idx;
  logic [ADDR_W-1:0] per_idx;
  logic [ADDR_W-1:0] low_idx;

  // pins from the outside world pass two flops first
  always_ff @(posedge clk)
  begin
    req_meta <= bus_request_pin;
    req_sync <= req_meta;
    ucs_meta <= upper_region_select_in;
    ucs_sync <= ucs_meta;
    lcs_meta <= lower_region_select_in;
    lcs_sync <= lcs_meta;
    srst_q <= srst;
  end

  // straps are caught on the first clock after reset releases
  assign next_iso = isolation_mode | (srst_q & ~ucs_sync & ~lcs_sync);

  always_ff @(posedge clk)
  begin
    isolation_mode <= ~srst & next_iso;
  end

  // pull-up keeps the lower select strap high unless driven low
  always_ff @(posedge clk)
  begin
    lower_pullup_en <= srst;
  end

  // a pending refresh in enhanced mode refuses a fresh grant too
  assign grant_ok = req_sync & ~(cfg.enhanced & refresh_pending);

  // address decode of the cycle waiting to start
  assign low_idx = blk_index(cycle.addr, {ADDR_W{1'b0}}, cfg.lower_log2);
  assign mid_idx = blk_index(cycle.addr, cfg.mid_base, cfg.mid_block_log2);
  assign per_idx = blk_index(cycle.addr, cfg.per_base, PER_BLOCK_LOG2);
  assign lower_hit = cycle.mem & (low_idx == {ADDR_W{1'b0}});

  genvar gi;
  generate
    for (gi = 0; gi < MID_COUNT; gi++)
    begin : g_mid
      assign mid_hits[gi] = cycle.mem & (mid_idx == ADDR_W'(gi));
    end
    for (gi = 0; gi < PER_COUNT; gi++)
    begin : g_per
      assign per_hits[gi] = (cycle.mem == cfg.per_in_mem) & (per_idx == ADDR_W'(gi));
    end
  endgenerate

  // cycle sequencer; hold is granted only between cycles
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (grant_ok)
          begin
            state <= ST_HOLD;
          end
          else if (cycle.valid)
          begin
            state <= ST_T1;
          end
        end
        ST_T1: state <= ST_T2;
        ST_T2: state <= ST_T3;
        ST_T3: state <= ST_T4;
        ST_T4: state <= ST_IDLE;
        ST_HOLD: state <= req_sync ? ST_HOLD : ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    cycle_ack <= ~srst & (state == ST_T3);
  end

  // grant only ever falls while holding, so a refresh yield sticks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_grant_out <= 1'b0;
      bus_grant_oe <= 1'b0;
    end
    else
    begin
      bus_grant_oe <= ~next_iso;
      if (state == ST_IDLE)
      begin
        bus_grant_out <= grant_ok;
      end
      else if (state == ST_HOLD)
      begin
        bus_grant_out <= bus_grant_out & grant_ok;
      end
      else
      begin
        bus_grant_out <= 1'b0;
      end
    end
  end

  // bus stays floated after hold until the next cycle needs it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_lines_oe <= 1'b0;
    end
    else if (next_iso || (state == ST_IDLE && grant_ok))
    begin
      bus_lines_oe <= 1'b0;
    end
    else if (state == ST_IDLE && cycle.valid)
    begin
      bus_lines_oe <= 1'b1;
    end
  end

  // chip selects: active low, framed by T1 to T4, never floated by hold
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lower_region_select <= 1'b1;
      midrange_selects <= MID_IDLE;
      peripheral_selects <= PER_IDLE[PER_LOW_COUNT-1:0];
      select_oe <= 1'b0;
    end
    else
    begin
      select_oe <= ~next_iso;
      if (state == ST_IDLE && cycle.valid && !grant_ok)
      begin
        lower_region_select <= ~lower_hit;
        midrange_selects <= ~mid_hits;
        peripheral_selects <= ~per_hits[PER_LOW_COUNT-1:0];
      end
      else if (state == ST_T4)
      begin
        lower_region_select <= 1'b1;
        midrange_selects <= MID_IDLE;
        peripheral_selects <= PER_IDLE[PER_LOW_COUNT-1:0];
      end
    end
  end

  // selects 5 and 6 or latched address copies that survive a hold
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      periph_sel5_or_latched_addr1 <= 1'b1;
      periph_sel6_or_latched_addr2 <= 1'b1;
    end
    else if (state == ST_IDLE && cycle.valid && !grant_ok)
    begin
      if (cfg.latched_addr_mode)
      begin
        periph_sel5_or_latched_addr1 <= cycle.addr[LATCH_A1_BIT];
        periph_sel6_or_latched_addr2 <= cycle.addr[LATCH_A2_BIT];
      end
      else
      begin
        periph_sel5_or_latched_addr1 <= ~per_hits[PER_LOW_COUNT];
        periph_sel6_or_latched_addr2 <= ~per_hits[PER_LOW_COUNT+1];
      end
    end
    else if (state == ST_T4 && !cfg.latched_addr_mode)
    begin
      periph_sel5_or_latched_addr1 <= 1'b1;
      periph_sel6_or_latched_addr2 <= 1'b1;
    end
  end

  // direction moves only on entry to T1 while enable is still high
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      transceiver_direction <= 1'b0;
      transceiver_direction_oe <= 1'b0;
    end
    else if (next_iso || state == ST_HOLD || (state == ST_IDLE && grant_ok))
    begin
      transceiver_direction_oe <= 1'b0;
    end
    else if (state == ST_IDLE && cycle.valid)
    begin
      transceiver_direction <= cycle.write;
      transceiver_direction_oe <= 1'b1;
    end
  end

  // enable: driven high on the first reset clock, then floated
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      transceiver_enable <= 1'b1;
      transceiver_enable_oe <= ~srst_q;
    end
    else if (next_iso || state == ST_HOLD || (state == ST_IDLE && grant_ok))
    begin
      transceiver_enable <= 1'b1;
      transceiver_enable_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          transceiver_enable <= 1'b1;
          if (cycle.valid)
          begin
            transceiver_enable_oe <= 1'b1;
          end
        end
        ST_T1: transceiver_enable <= 1'b0;
        ST_T2: transceiver_enable <= 1'b0;
        ST_T3: transceiver_enable <= 1'b1;
        default: transceiver_enable <= 1'b1;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_grant_floats_bus: assert property ($rose(bus_grant_out) |-> !bus_lines_oe && state == ST_HOLD)
    else $error("grant rose without floating the bus");
  a_grant_drop: assert property (state == ST_HOLD && !req_sync |=> !bus_grant_out && state == ST_IDLE)
    else $error("grant stayed high after request fell");
  a_refresh_yield: assert property (state == ST_HOLD && cfg.enhanced && refresh_pending |=> !bus_grant_out)
    else $error("grant not dropped for pending refresh");
  a_lower_hit: assert property (state == ST_IDLE && cycle.valid && !grant_ok && lower_hit && !next_iso |=> !lower_region_select [*4])
    else $error("lower select not low for its region");
  a_selects_driven: assert property (state == ST_HOLD && !isolation_mode |-> select_oe)
    else $error("chip selects floated during hold");
  a_iso_floats: assert property (isolation_mode |-> !select_oe && !bus_grant_oe && !transceiver_enable_oe && !transceiver_direction_oe)
    else $error("pin driven in isolation mode");
  a_pullup_reset: assert property (disable iff (1'b0) ##1 lower_pullup_en == $past(srst))
    else $error("pull-up not tied to reset");
  a_addr2_hold: assert property (state == ST_HOLD && $past(state) == ST_HOLD && cfg.latched_addr_mode |-> $stable(periph_sel6_or_latched_addr2))
    else $error("latched address moved during hold");
  a_dir_float: assert property (state == ST_HOLD |-> !transceiver_direction_oe)
    else $error("direction driven during hold");
  a_den_access: assert property (state == ST_T2 && !isolation_mode |-> !transceiver_enable ##1 !transceiver_enable ##1 transceiver_enable)
    else $error("enable not low through the access");
  a_den_dir_change: assert property ($changed(transceiver_direction) |-> transceiver_enable && $past(transceiver_enable))
    else $error("direction changed while enabled");
  a_den_reset: assert property (disable iff (1'b0) $rose(srst) |=> transceiver_enable_oe && transceiver_enable ##1 (!transceiver_enable_oe || !srst))
    else $error("enable not one clock high at reset");

  c_hold_grant: cover property (state == ST_IDLE && grant_ok ##1 bus_grant_out ##[1:20] !bus_grant_out);
  c_refresh_yield: cover property (bus_grant_out && cfg.enhanced && refresh_pending ##1 !bus_grant_out && state == ST_HOLD);
  c_write_cycle: cover property (state == ST_T1 && transceiver_direction ##3 cycle_ack);
  c_isolation: cover property (isolation_mode);

endmodule : lbhs_top
`default_nettype wire

// file: rtl/lbhs_pkg.sv
// package for the local bus hold and chip-select pin block
package lbhs_pkg;

  localparam int ADDR_W = 20;
  localparam int LOG2_W = 5;
  localparam int MID_COUNT = 4;
  localparam int PER_COUNT = 7;
  localparam int PER_LOW_COUNT = 5;
  localparam logic [LOG2_W-1:0] PER_BLOCK_LOG2 = 5'h07;
  localparam int LATCH_A1_BIT = 1;
  localparam int LATCH_A2_BIT = 2;
  localparam logic [ADDR_W-1:0] NO_BLOCK = 20'hF_FFFF;
  localparam logic [MID_COUNT-1:0] MID_IDLE = 4'hF;
  localparam logic [PER_COUNT-1:0] PER_IDLE = 7'h7F;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_T1 = 6'h02,
    ST_T2 = 6'h04,
    ST_T3 = 6'h08,
    ST_T4 = 6'h10,
    ST_HOLD = 6'h20
  } lbhs_state_t;

  // one bus cycle as issued by the core
  typedef struct packed {
    logic valid;
    logic mem;
    logic write;
    logic [ADDR_W-1:0] addr;
  } lbhs_cycle_t;

  // static setup from the core's select configuration
  typedef struct packed {
    logic enhanced;
    logic [LOG2_W-1:0] lower_log2;
    logic [ADDR_W-1:0] mid_base;
    logic [LOG2_W-1:0] mid_block_log2;
    logic [ADDR_W-1:0] per_base;
    logic per_in_mem;
    logic latched_addr_mode;
  } lbhs_cfg_t;

endpackage : lbhs_pkg

// file: verification/lbhs_master_model.sv
// second bus master that asks for the local bus and gives it back
`timescale 1ns/1ps
`default_nettype none
module lbhs_master_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic want,
  input wire logic bus_grant_out,
  output logic bus_request_pin
);
  logic owned;
  logic done;

  initial bus_request_pin = 1'b0;
  initial owned = 1'b0;
  initial done = 1'b0;

  // grant lost while owning means a refresh wants the bus: let go until asked again
  always @(negedge clk)
  begin
    if (srst || !want)
    begin
      bus_request_pin <= 1'b0;
      owned <= 1'b0;
      done <= 1'b0;
    end
    else if (owned && !bus_grant_out)
    begin
      bus_request_pin <= 1'b0;
      done <= 1'b1;
    end
    else if (!done)
    begin
      bus_request_pin <= 1'b1;
      owned <= owned | bus_grant_out;
    end
  end
endmodule : lbhs_master_model
`default_nettype wire

// file: verification/test_lbhs_top.sv
// self-checking bench for the hold handshake, selects and transceiver pins
`timescale 1ns/1ps
`default_nettype none
module test_lbhs_top;
  import lbhs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b0;
  logic want = 1'b0;
  logic refresh = 1'b0;
  logic up_in = 1'b1;
  logic lo_in = 1'b1;
  logic req, ack, grant, grant_oe, bus_oe, lower, pull, a1, a2, sel_oe;
  logic dir, dir_oe, en, en_oe, iso;
  logic [3:0] mid;
  logic [4:0] per;
  lbhs_cycle_t cyc = '0;
  lbhs_cfg_t cfg;
  int error_cnt = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  lbhs_top i_dut (.clk(clk), .srst(srst), .bus_request_pin(req), .upper_region_select_in(up_in),
    .lower_region_select_in(lo_in), .cycle(cyc), .cfg(cfg), .refresh_pending(refresh),
    .cycle_ack(ack), .bus_grant_out(grant), .bus_grant_oe(grant_oe), .bus_lines_oe(bus_oe),
    .lower_region_select(lower), .lower_pullup_en(pull), .midrange_selects(mid),
    .peripheral_selects(per), .periph_sel5_or_latched_addr1(a1),
    .periph_sel6_or_latched_addr2(a2), .select_oe(sel_oe), .transceiver_direction(dir),
    .transceiver_direction_oe(dir_oe), .transceiver_enable(en),
    .transceiver_enable_oe(en_oe), .isolation_mode(iso));

  lbhs_master_model i_master (.clk(clk), .srst(srst), .want(want), .bus_grant_out(grant),
    .bus_request_pin(req));

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic do_reset(input logic strap_low);
    @(negedge clk);
    up_in = !strap_low;
    lo_in = !strap_low;
    srst = 1'b1;
    @(negedge clk);
    check({en_oe, en}, 2'b11);
    @(negedge clk);
    check({en_oe, dir_oe, pull}, 3'b001);
    repeat (14) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    check(pull, 1'b0);
    check({iso, grant_oe, sel_oe, bus_oe, dir_oe, en_oe}, {strap_low, !strap_low, !strap_low, 3'b000});
  endtask : do_reset

  // exp packs lower, mid, peripheral, sel6/a2, sel5/a1 as seen during T1
  task automatic run_cycle(input logic mem, input logic wr, input logic [19:0] addr,
    input logic [11:0] exp);
    cyc = '{valid: 1'b1, mem: mem, write: wr, addr: addr};
    @(negedge clk);
    check({lower, mid, per, a2, a1}, exp);
    check({dir, dir_oe, bus_oe, en, en_oe}, {wr, 4'hF});
    @(negedge clk);
    check({en, dir}, {1'b0, wr});
    repeat (2) @(negedge clk);
    check({ack, en}, 2'b11);
    cyc.valid = 1'b0;
    @(negedge clk);
    check({lower, mid, per}, 10'h3FF);
  endtask : run_cycle

  task automatic wait_grant(input logic level);
    int n;
    n = 0;
    while (grant !== level && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    check(grant, level);
  endtask : wait_grant

  task automatic test_selects();
    run_cycle(1'b1, 1'b0, 20'h0_03FF, 12'h7FF);
    run_cycle(1'b1, 1'b0, 20'h0_0400, 12'hFFF);
    run_cycle(1'b1, 1'b1, 20'h8_4000, 12'hDFF);
    run_cycle(1'b0, 1'b1, 20'h0_0580, 12'hFDF);
    run_cycle(1'b0, 1'b0, 20'h0_0680, 12'hFFE);
    run_cycle(1'b0, 1'b0, 20'h0_0700, 12'hFFD);
    run_cycle(1'b0, 1'b0, 20'h0_03FF, 12'hFFF);
    cfg.per_in_mem = 1'b1;
    run_cycle(1'b1, 1'b0, 20'h0_0400, 12'hFFB);
    cfg.per_in_mem = 1'b0;
  endtask : test_selects

  task automatic test_hold();
    cfg.latched_addr_mode = 1'b1;
    run_cycle(1'b0, 1'b0, 20'h0_0684, 12'hFFE);
    want = 1'b1;
    wait_grant(1'b1);
    check({bus_oe, dir_oe, en_oe, sel_oe}, 4'h1);
    repeat (6) @(negedge clk);
    check({grant, sel_oe, a2, a1}, 4'hE);
    want = 1'b0;
    wait_grant(1'b0);
    check(bus_oe, 1'b0);
    run_cycle(1'b1, 1'b0, 20'h0_0002, 12'h7FD);
    cfg.latched_addr_mode = 1'b0;
  endtask : test_hold

  task automatic test_refresh();
    cfg.enhanced = 1'b1;
    want = 1'b1;
    wait_grant(1'b1);
    refresh = 1'b1;
    repeat (2) @(negedge clk);
    check({grant, bus_oe}, 2'b00);
    repeat (4) @(negedge clk);
    check({req, grant}, 2'b00);
    refresh = 1'b0;
    want = 1'b0;
    cfg.enhanced = 1'b0;
    run_cycle(1'b1, 1'b1, 20'h8_0000, 12'hF7F);
  endtask : test_refresh

  initial
  begin
    cfg = '{enhanced: 1'b0, lower_log2: 5'h0A, mid_base: 20'h8_0000, mid_block_log2: 5'h0D,
      per_base: 20'h0_0400, per_in_mem: 1'b0, latched_addr_mode: 1'b0};
    do_reset(1'b0);
    test_selects();
    test_hold();
    test_refresh();
    do_reset(1'b1);
    do_reset(1'b0);
    print_verdict();
  end

  // the run needs well under a thousand cycles
  initial
  begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule : test_lbhs_top
`default_nettype wire
